// *** rtl/mwd_map.vh ***
/*
  register map, field positions, reset values and timing counts of the
  millisecond watchdog.
  assumes the includer works on 32-bit apb words, byte address = 4 * index.
*/
`ifndef MWD_MAP_VH
`define MWD_MAP_VH

// register indices; byte address is four times the index
`define MWD_IDX_FREQ         10'h051
`define MWD_IDX_TIMEOUT      10'h0d6
`define MWD_IDX_DISABLE      10'h0d7
`define MWD_IDX_STATUS       10'h0d8

// timeout register fields
`define MWD_TMO_LSB          0
`define MWD_TMO_MSB          15
`define MWD_CNT_LSB          16
`define MWD_CNT_MSB          31

// frequency field
`define MWD_FREQ_MSB         6
`define MWD_FREQ_MIN         7'h05
`define MWD_FREQ_MAX         7'h64

// status fields
`define MWD_ST_ENABLED       0
`define MWD_ST_NACK          1
`define MWD_ST_EXPIRED       2
`define MWD_ST_FULL_RUN_POWER_STATE         3

// reset values
`define MWD_RST_TIMEOUT      16'h03e8
`define MWD_RST_DISABLE      32'h0d15_ab1e
`define MWD_RST_FREQ         7'h19
`define MWD_ENABLE_KEY       32'h0000_0000
`define MWD_DISABLE_KEY      32'h0d15_ab1e

// timing: tick period in microseconds; cycles per tick = mhz * tick_us
`define MWD_TICK_US          10'h3e8

`endif

// *** rtl/mwd_tick_gen.v ***
/*
  1 ms tick generator for the watchdog, divided from the core clock
  according to the oscillator frequency setting in mhz.
  assumes freq_mhz only holds accepted values (5 to 100) and that run
  reflects the full-run power state.
*/
`timescale 1ns/1ps
`include "mwd_map.vh"

module mwd_tick_gen (
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       run,
  input  wire [6:0] freq_mhz,
  output reg        tick
);

  wire [16:0] cycles_per_tick;
  reg  [16:0] div_count;

  // largest is 100 * 1000 = 100000, fits 17 bits
  assign cycles_per_tick = {10'h000, freq_mhz} * {7'h00, `MWD_TICK_US};

  always @(posedge core_clk) begin
    if (!resetn) begin
      div_count <= 17'h0_0000;
      tick      <= 1'b0;
    end else if (!run) begin
      // divider holds outside the full-run state, so no partial tick is lost
      tick      <= 1'b0;
    end else if (div_count >= cycles_per_tick - 17'h0_0001) begin
      // >= guards against a lowered frequency leaving the count above limit
      div_count <= 17'h0_0000;
      tick      <= 1'b1;
    end else begin
      div_count <= div_count + 17'h0_0001;
      tick      <= 1'b0;
    end
  end

endmodule

// *** rtl/mwd_top.v ***
/*
  millisecond watchdog timer with apb register access: timeout and live
  count, disable key, oscillator frequency and a status word.
  assumes an apb master that holds each request until pready, a
  synchronous active-low reset and a power-state level input.
*/
// How it works
// - timeout counts in 1 ms ticks, 1 ms up to about 65 s
// - watchdog only advances in the full-run power state; otherwise count holds
// - bad complement gets pslverr (nack); good write gets okay (ack)
// - enabled countdown reaching expiry pulses the tile reset
// - each kick restarts the countdown from the full programmed timeout
// - live count reads back in the upper half of the timeout register
// - lower half is read-write timeout, reset value one thousand
// - writing zero to the disable register enables the countdown
// - writing the magic key reloads the count and stops the watchdog
// - disable register resets to the magic key, watchdog starts disabled
// - tick derived from 7-bit mhz setting, default 25, only 5..100 accepted
`timescale 1ns/1ps
`include "mwd_map.vh"

module mwd_top (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire        full_run_power_state,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         tile_reset,
  output reg         watchdog_running
);

  reg  [15:0] timeout;
  reg  [15:0] count;
  reg  [31:0] disable_key;
  reg  [6:0]  freq_mhz;
  reg         last_nack;
  reg         expired;

  wire        tick;
  wire        access;
  wire        commit;
  wire [9:0]  word_idx;
  wire        hit_freq;
  wire        hit_timeout;
  wire        hit_disable;
  wire        hit_status;
  wire        hit_any;
  wire        tmo_ok;
  wire        freq_ok;
  wire        wr_timeout;
  wire        wr_disable;
  wire        wr_freq;
  wire        wr_status;
  wire        expire_now;
  wire        bad_write;
  reg  [31:0] next_prdata;

  function is_complement;
    input [31:0] word;
    begin
      is_complement = (word[`MWD_CNT_MSB:`MWD_CNT_LSB] == ~word[`MWD_TMO_MSB:`MWD_TMO_LSB]);
    end
  endfunction

  function in_freq_range;
    input [6:0] mhz;
    begin
      in_freq_range = (mhz >= `MWD_FREQ_MIN) && (mhz <= `MWD_FREQ_MAX);
    end
  endfunction

  mwd_tick_gen u_tick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (full_run_power_state),
    .freq_mhz (freq_mhz),
    .tick     (tick)
  );

  // apb decode; low two address bits ignored, word aligned
  assign word_idx    = paddr[11:2];
  assign hit_freq    = (word_idx == `MWD_IDX_FREQ);
  assign hit_timeout = (word_idx == `MWD_IDX_TIMEOUT);
  assign hit_disable = (word_idx == `MWD_IDX_DISABLE);
  assign hit_status  = (word_idx == `MWD_IDX_STATUS);
  assign hit_any     = hit_freq | hit_timeout | hit_disable | hit_status;

  // access phase before the answer; commit is the edge pready is sampled high
  assign access = psel & penable & ~pready;
  assign commit = psel & penable & pready;

  assign tmo_ok  = is_complement(pwdata);
  assign freq_ok = in_freq_range(pwdata[`MWD_FREQ_MSB:0]);

  assign wr_timeout = commit & pwrite & hit_timeout & tmo_ok;
  assign wr_disable = commit & pwrite & hit_disable;
  assign wr_freq    = commit & pwrite & hit_freq & freq_ok;
  assign wr_status  = commit & pwrite & hit_status;

  // rejected writes: bad complement, out-of-range frequency; unmapped accesses are flagged via hit_any
  assign bad_write = pwrite & ((hit_timeout & ~tmo_ok) | (hit_freq & ~freq_ok));

  assign expire_now = watchdog_running & tick & (count <= 16'h0001);

  // read mux
  always @* begin
    next_prdata = 32'h0000_0000;
    if (!pwrite) begin
      if (hit_timeout) begin
        next_prdata = {count, timeout};
      end else if (hit_disable) begin
        next_prdata = disable_key;
      end else if (hit_freq) begin
        next_prdata = {25'h000_0000, freq_mhz};
      end else if (hit_status) begin
        next_prdata = {28'h000_0000, full_run_power_state, expired, last_nack, watchdog_running};
      end
    end
  end

  // one wait state: answer registered so outputs come from flops
  always @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (access) begin
      pready  <= 1'b1;
      pslverr <= ~hit_any | bad_write;
      prdata  <= next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // timeout field
  always @(posedge core_clk) begin
    if (!resetn) begin
      timeout <= `MWD_RST_TIMEOUT;
    end else if (wr_timeout) begin
      timeout <= pwdata[`MWD_TMO_MSB:`MWD_TMO_LSB];
    end
  end

  // frequency setting; out-of-range writes leave it untouched
  always @(posedge core_clk) begin
    if (!resetn) begin
      freq_mhz <= `MWD_RST_FREQ;
    end else if (wr_freq) begin
      freq_mhz <= pwdata[`MWD_FREQ_MSB:0];
    end
  end

  // disable key and run state; other values are stored but change nothing
  always @(posedge core_clk) begin
    if (!resetn) begin
      disable_key      <= `MWD_RST_DISABLE;
      watchdog_running <= 1'b0;
    end else if (wr_disable) begin
      disable_key <= pwdata;
      if (pwdata == `MWD_ENABLE_KEY) begin
        watchdog_running <= 1'b1;
      end else if (pwdata == `MWD_DISABLE_KEY) begin
        watchdog_running <= 1'b0;
      end
    end
  end

  // countdown; kicks and key writes take priority over a tick in the same cycle
  always @(posedge core_clk) begin
    if (!resetn) begin
      count <= `MWD_RST_TIMEOUT;
    end else if (wr_timeout) begin
      count <= pwdata[`MWD_TMO_MSB:`MWD_TMO_LSB];
    end else if (wr_disable && (pwdata == `MWD_DISABLE_KEY || pwdata == `MWD_ENABLE_KEY)) begin
      count <= timeout;
    end else if (expire_now) begin
      count <= timeout;
    end else if (watchdog_running && tick) begin
      // tick only occurs in the full-run state, so the count holds elsewhere
      count <= count - 16'h0001;
    end
  end

  // tile reset pulse, one cycle per expiry
  always @(posedge core_clk) begin
    if (!resetn) begin
      tile_reset <= 1'b0;
    end else begin
      tile_reset <= expire_now;
    end
  end

  // status flags; hardware set wins over software clear
  always @(posedge core_clk) begin
    if (!resetn) begin
      last_nack <= 1'b0;
      expired   <= 1'b0;
    end else begin
      if (commit && pwrite) begin
        last_nack <= pslverr;
      end
      if (expire_now) begin
        expired <= 1'b1;
      end else if (wr_status && pwdata[`MWD_ST_EXPIRED]) begin
        expired <= 1'b0;
      end
    end
  end

endmodule

// *** verification/mwd_top_props.sv ***
/* checker for mwd_top: apb answer timing, timeout key guard, enable keys.
   assumes the register map header on the include path. */
`timescale 1ns/1ps
`include "mwd_map.vh"
module mwd_top_props (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        full_run_power_state,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tile_reset,
  input wire logic        watchdog_running
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // first access cycle, before the one wait state ends
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_wr(idx);
    s_wait ##0 pwrite && paddr[11:2] == idx;
  endsequence
  a_wait_one: assert property (s_wait |=> pready)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("bus outputs not quiet");
  a_bad_key_nack: assert property (s_wr(`MWD_IDX_TIMEOUT) ##0 pwdata[31:16] != ~pwdata[15:0] |=> pslverr)
    else $error("bad complement accepted");
  a_good_key_ack: assert property (s_wr(`MWD_IDX_TIMEOUT) ##0 pwdata[31:16] == ~pwdata[15:0] |=> !pslverr)
    else $error("good complement refused");
  a_pulse_once: assert property (tile_reset |=> !tile_reset)
    else $error("tile reset longer than a cycle");
  // state lands at the pready edge, so seen two cycles on
  a_key_stops: assert property (s_wr(`MWD_IDX_DISABLE) ##0 pwdata == `MWD_DISABLE_KEY |-> ##2 !watchdog_running)
    else $error("magic key did not stop");
  a_zero_runs: assert property (s_wr(`MWD_IDX_DISABLE) ##0 pwdata == `MWD_ENABLE_KEY |-> ##2 watchdog_running)
    else $error("zero did not enable");
endmodule
bind mwd_top mwd_top_props u_props (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .full_run_power_state(full_run_power_state),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tile_reset(tile_reset),
  .watchdog_running(watchdog_running));

// *** verification/mwd_top_tb.sv ***
/* self-checking bench for mwd_top: reset values, key guard, expiry, power hold.
   assumes mwd_top_props is bound to the design. */
`timescale 1ns/1ps
module mwd_top_tb;
  logic        core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        full_run_power_state = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, tile_reset, watchdog_running, err;
  int          miscompares = 0, check_count = 0, cyc = 0, n, hits;
  mwd_top dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .full_run_power_state(full_run_power_state), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tile_reset(tile_reset), .watchdog_running(watchdog_running));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask
  // waits on pready, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rst;
    n = 0;
    while (tile_reset !== 1'b1 && n < 12000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic t_reset;
    apb(0, 12'h358, 32'h0000_0000);
    chk("timeout reg", 32'h03e8_03e8, rd);
    apb(0, 12'h35c, 32'h0000_0000);
    chk("disable reg", 32'h0d15_ab1e, rd);
    chk("running", 32'h0000_0000, 32'(watchdog_running));
    apb(0, 12'h144, 32'h0000_0000);
    chk("freq reg", 32'h0000_0019, rd);
    apb(0, 12'h3fc, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(err));
    $display("t_reset done");
  endtask
  task automatic t_key;
    apb(1, 12'h358, 32'h1234_0002);
    chk("bad key err", 32'h0000_0001, 32'(err));
    apb(0, 12'h358, 32'h0000_0000);
    chk("kept timeout", 32'h03e8_03e8, rd);
    apb(1, 12'h358, 32'hfffd_0002);
    chk("good key err", 32'h0000_0000, 32'(err));
    apb(0, 12'h358, 32'h0000_0000);
    chk("new timeout", 32'h0002_0002, rd);
    $display("t_key done");
  endtask
  // freq 5 gives a 5000 cycle tick, so timeout 2 expires in 5000..10000
  task automatic t_expire;
    apb(1, 12'h144, 32'h0000_0005);
    apb(1, 12'h144, 32'h0000_0065);
    chk("bad freq err", 32'h0000_0001, 32'(err));
    apb(0, 12'h144, 32'h0000_0000);
    chk("freq kept", 32'h0000_0005, rd);
    apb(1, 12'h35c, 32'h0000_0000);
    // run state lands at the pready edge; look one edge later
    @(posedge core_clk);
    chk("enabled", 32'h0000_0001, 32'(watchdog_running));
    wait_rst();
    chk("expiry wait", 32'h0000_0001, 32'(n >= 4990 && n <= 10010));
    apb(0, 12'h360, 32'h0000_0000);
    chk("status", 32'h0000_000d, rd);
    full_run_power_state <= 1'b0;
    apb(1, 12'h358, 32'hfffd_0002);
    hits = 0;
    repeat (12000) @(posedge core_clk) if (tile_reset !== 1'b0) hits++;
    chk("asleep resets", 32'h0000_0000, 32'(hits));
    apb(0, 12'h358, 32'h0000_0000);
    chk("held count", 32'h0002_0002, rd);
    full_run_power_state <= 1'b1;
    wait_rst();
    chk("kick wait", 32'h0000_0001, 32'(n >= 4990 && n <= 10010));
    apb(1, 12'h35c, 32'h0d15_ab1e);
    @(posedge core_clk);
    chk("stopped", 32'h0000_0000, 32'(watchdog_running));
    apb(0, 12'h358, 32'h0000_0000);
    chk("reloaded", 32'h0002_0002, rd);
    $display("t_expire done");
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_key();
    t_expire();
    tally_and_finish();
  end
endmodule
